// ===== spsr_regs.sv
// Slot status, common status and special function registers.
`timescale 1ns/1ps
//
// Function
// - Slot fault flag mirrors low fault pin unless forced on.
// - Overcurrent clears after condition ends plus echo.
// - Force-on low releases fault pin, flag kept.
// - Slot fault flag inactive under bus control.
// - Main state set when enabled, no fault, no lockout, not forced.
// - Aux state follows internal aux enable.
// - Aux overcurrent on timer or thermal one.
// - Twelve volt overcurrent incl fast trip.
// - Three volt overcurrent incl fast trip.
// - Write one clears flag, releases interrupt.
// - General inputs deglitched five milliseconds.
// - Mask zero lets faults pull interrupt low.
// - Undervoltage flag only while mains enabled.
// - Overtemp flag on thermal stage two.
// - Function read never returns zero.
// - Aux limit is bit ORed with pin.
// - Power-off bit when all outputs low.
// - Main limit bit enables normal limit.
// - Low function bit is fixed signature.
// - Reserved bits read zero.
// - Echo clear happens on next read.
module spsr_regs #(
  parameter int DEGLITCH = spsr_pkg::DEGLITCH_CYCLES
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  // Register access
  input  wire spsr_pkg::spsr_req_t req,
  output logic [7:0]              rdata,
  output logic                    rvalid,
  // Slot conditions
  input  wire spsr_pkg::spsr_slot_t slot_a,
  input  wire spsr_pkg::spsr_slot_t slot_b,
  input  wire logic               smbus_mode,
  input  wire logic               thermal_stage_one,
  input  wire logic               thermal_stage_two,
  // Pins
  input  wire logic [1:0]         force_on_pin_n,
  input  wire logic [1:0]         aux_high_pin,
  input  wire logic [3:0]         general_input,
  output logic [1:0]              fault_pin_o,
  output logic [1:0]              fault_pin_oe_n,
  output logic                    irq_pin_o,
  output logic                    irq_pin_oe_n,
  // Limit controls
  output logic [1:0]              aux_limit_high,
  output logic [1:0]              main_normal_limit_en
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [1:0] force_n_s;
  logic [1:0] auxhi_s;
  logic [3:0] gpi_s;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
    end else if (clk_en) begin
      pin_s1_r <= {force_on_pin_n, aux_high_pin, general_input};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign force_n_s = pin_s2_r[7:6];
  assign auxhi_s   = pin_s2_r[5:4];
  assign gpi_s     = pin_s2_r[3:0];

  // ****************************************
  // Deglitch of general inputs
  // ****************************************
  logic [3:0]  gpi_r;
  logic [31:0] gpi_cnt_r [4];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gpi_r <= 4'h0;
      for (int i = 0; i < 4; i++) gpi_cnt_r[i] <= 32'h0000_0000;
    end else if (clk_en) begin
      for (int i = 0; i < 4; i++) begin
        if (gpi_s[i] == gpi_r[i]) begin
          gpi_cnt_r[i] <= 32'h0000_0000;
        end else if (gpi_cnt_r[i] >= 32'(DEGLITCH - 1)) begin
          gpi_r[i]     <= gpi_s[i];
          gpi_cnt_r[i] <= 32'h0000_0000;
        end else begin
          gpi_cnt_r[i] <= gpi_cnt_r[i] + 32'h0000_0001;
        end
      end
    end
  end

  // ****************************************
  // Write legality
  // ****************************************
  function automatic logic fn_write_legal(input logic [7:0] v);
    fn_write_legal = (v[0] == 1'b1) && ((v & ~8'hcd) == 8'h00);
  endfunction : fn_write_legal

  function automatic logic mask_legal(input logic [7:0] v, input logic [7:0] m);
    mask_legal = ((v & ~m) == 8'h00);
  endfunction : mask_legal

  // ****************************************
  // Sticky fault flags with echo reset
  // ****************************************
  // Per flag: sticky bit and an armed echo that fires on the next read.
  logic [2:0] a_flag_r;
  logic [2:0] a_echo_r;
  logic [2:0] b_flag_r;
  logic [2:0] b_echo_r;
  logic [1:0] c_flag_r;
  logic [1:0] c_echo_r;
  logic [2:0] a_cond;
  logic [2:0] b_cond;
  logic [1:0] c_cond;
  logic       wr_a;
  logic       wr_b;
  logic       wr_c;
  logic       wr_f;
  logic       rd_a;
  logic       rd_b;
  logic       rd_c;

  assign wr_a = req.wr && req.addr == spsr_pkg::ADDR_SLOT_A_STATUS
                && mask_legal(req.wdata, spsr_pkg::SS_WRITE_MASK);
  assign wr_b = req.wr && req.addr == spsr_pkg::ADDR_SLOT_B_STATUS
                && mask_legal(req.wdata, spsr_pkg::SS_WRITE_MASK);
  assign wr_c = req.wr && req.addr == spsr_pkg::ADDR_COMMON_STATUS
                && mask_legal(req.wdata, spsr_pkg::CS_WRITE_MASK);
  assign wr_f = req.wr && req.addr == spsr_pkg::ADDR_SPECIAL_FUNCTION
                && fn_write_legal(req.wdata);
  assign rd_a = req.rd && req.addr == spsr_pkg::ADDR_SLOT_A_STATUS;
  assign rd_b = req.rd && req.addr == spsr_pkg::ADDR_SLOT_B_STATUS;
  assign rd_c = req.rd && req.addr == spsr_pkg::ADDR_COMMON_STATUS;

  function automatic logic [2:0] oc_cond(input spsr_pkg::spsr_slot_t s, input logic t1);
    oc_cond[2] = s.aux_oc && (s.timer_expired || t1);
    oc_cond[1] = (s.r12_oc && (s.timer_expired || t1)) || s.r12_fast_trip;
    oc_cond[0] = (s.r3_oc && (s.timer_expired || t1)) || s.r3_fast_trip;
  endfunction : oc_cond

  function automatic logic [2:0] wbits(input logic [7:0] v);
    wbits = {v[spsr_pkg::SS_AUXOC_BIT], v[spsr_pkg::SS_R12OC_BIT], v[spsr_pkg::SS_R3OC_BIT]};
  endfunction : wbits

  assign a_cond = oc_cond(slot_a, thermal_stage_one);
  assign b_cond = oc_cond(slot_b, thermal_stage_one);
  assign c_cond = {(slot_a.uvlo && slot_a.main_en) || (slot_b.uvlo && slot_b.main_en),
                   thermal_stage_two};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      a_flag_r <= 3'b000;
      a_echo_r <= 3'b000;
    end else if (clk_en) begin
      // A present condition sets the flag and wins over any echo clear.
      if (wr_a) a_echo_r <= a_echo_r | (wbits(req.wdata) & a_flag_r);
      if (rd_a) begin
        a_flag_r <= (a_flag_r & ~a_echo_r) | a_cond;
        a_echo_r <= 3'b000;
      end else begin
        a_flag_r <= a_flag_r | a_cond;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      b_flag_r <= 3'b000;
      b_echo_r <= 3'b000;
    end else if (clk_en) begin
      if (wr_b) b_echo_r <= b_echo_r | (wbits(req.wdata) & b_flag_r);
      if (rd_b) begin
        b_flag_r <= (b_flag_r & ~b_echo_r) | b_cond;
        b_echo_r <= 3'b000;
      end else begin
        b_flag_r <= b_flag_r | b_cond;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      c_flag_r <= 2'b00;
      c_echo_r <= 2'b00;
    end else if (clk_en) begin
      if (wr_c) c_echo_r <= c_echo_r | (req.wdata[2:1] & c_flag_r);
      if (rd_c) begin
        c_flag_r <= (c_flag_r & ~c_echo_r) | c_cond;
        c_echo_r <= 2'b00;
      end else begin
        c_flag_r <= c_flag_r | c_cond;
      end
    end
  end

  // ****************************************
  // Writable control bits
  // ****************************************
  logic       mask_r;
  logic [1:0] auxsel_r;
  logic [1:0] mainlim_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= spsr_pkg::RST_COMMON_STATUS[spsr_pkg::CS_MASK_BIT];
    end else if (clk_en && wr_c) begin
      mask_r <= req.wdata[spsr_pkg::CS_MASK_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      auxsel_r  <= {spsr_pkg::RST_FUNCTION[spsr_pkg::FN_AUXB_BIT],
                    spsr_pkg::RST_FUNCTION[spsr_pkg::FN_AUXA_BIT]};
      mainlim_r <= {spsr_pkg::RST_FUNCTION[spsr_pkg::FN_MAINB_BIT],
                    spsr_pkg::RST_FUNCTION[spsr_pkg::FN_MAINA_BIT]};
    end else if (clk_en && wr_f) begin
      auxsel_r  <= {req.wdata[spsr_pkg::FN_AUXB_BIT], req.wdata[spsr_pkg::FN_AUXA_BIT]};
      mainlim_r <= {req.wdata[spsr_pkg::FN_MAINB_BIT], req.wdata[spsr_pkg::FN_MAINA_BIT]};
    end
  end

  // ****************************************
  // Status views
  // ****************************************
  // The fault flag tracks the drive decision, so it only lives in direct mode.
  logic [1:0] fault_drive;
  logic [7:0] stat_a;
  logic [7:0] stat_b;
  logic [7:0] stat_c;
  logic [7:0] stat_f;
  logic       uv_gate;

  assign fault_drive[0] = !smbus_mode && (a_flag_r != 3'b000 || slot_a.main_fault);
  assign fault_drive[1] = !smbus_mode && (b_flag_r != 3'b000 || slot_b.main_fault);

  function automatic logic [7:0] slot_view(input logic fault, input spsr_pkg::spsr_slot_t s,
                                           input logic [2:0] f);
    slot_view = 8'h00;
    slot_view[spsr_pkg::SS_FAULT_BIT] = fault;
    slot_view[spsr_pkg::SS_MAIN_BIT]  = s.main_en && !s.main_fault && !s.uvlo
                                        && !s.force_active;
    slot_view[spsr_pkg::SS_AUX_BIT]   = s.aux_en;
    slot_view[spsr_pkg::SS_AUXOC_BIT] = f[2];
    slot_view[spsr_pkg::SS_R12OC_BIT] = f[1];
    slot_view[spsr_pkg::SS_R3OC_BIT]  = f[0];
  endfunction : slot_view

  // The flag reflects the drive decision; force-on only opens the pin.
  assign stat_a = slot_view(fault_drive[0], slot_a, a_flag_r);
  assign stat_b = slot_view(fault_drive[1], slot_b, b_flag_r);
  // The lockout view is gated so it is hidden while both main supplies are disabled.
  assign uv_gate = slot_a.main_en || slot_b.main_en;
  assign stat_c = {gpi_r[3], gpi_r[2], gpi_r[1], gpi_r[0], mask_r,
                   c_flag_r[1] && uv_gate, c_flag_r[0], 1'b0};
  assign stat_f = {auxsel_r, slot_b.below_100mv, slot_a.below_100mv,
                   mainlim_r, 1'b0, 1'b1};

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
    end else if (clk_en) begin
      rvalid <= req.rd;
    end
  end

  // Data follows the address every cycle, so it only means something with rvalid.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      case (req.addr)
        spsr_pkg::ADDR_SLOT_A_STATUS:    rdata <= stat_a;
        spsr_pkg::ADDR_SLOT_B_STATUS:    rdata <= stat_b;
        spsr_pkg::ADDR_COMMON_STATUS:    rdata <= stat_c;
        spsr_pkg::ADDR_SPECIAL_FUNCTION: rdata <= stat_f;
        default:                         rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Pins and limit outputs
  // ****************************************
  // Both pins are open drain: the level stays low and only the enable moves.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_pin_o    <= 2'b00;
      fault_pin_oe_n <= 2'b11;
    end else if (clk_en) begin
      fault_pin_o    <= 2'b00;
      fault_pin_oe_n <= ~(fault_drive & force_n_s);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_pin_o    <= 1'b0;
      irq_pin_oe_n <= 1'b1;
    end else if (clk_en) begin
      irq_pin_o    <= 1'b0;
      irq_pin_oe_n <= mask_r || (a_flag_r == 3'b000 && b_flag_r == 3'b000
                                 && c_flag_r == 2'b00);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aux_limit_high <= {spsr_pkg::RST_FUNCTION[spsr_pkg::FN_AUXB_BIT],
                         spsr_pkg::RST_FUNCTION[spsr_pkg::FN_AUXA_BIT]};
    end else if (clk_en) begin
      aux_limit_high <= auxsel_r | auxhi_s;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_normal_limit_en <= {spsr_pkg::RST_FUNCTION[spsr_pkg::FN_MAINB_BIT],
                               spsr_pkg::RST_FUNCTION[spsr_pkg::FN_MAINA_BIT]};
    end else if (clk_en) begin
      main_normal_limit_en <= mainlim_r;
    end
  end

endmodule : spsr_regs

// ===== spsr_pkg.sv
// Package for the slot power status register bank.
package spsr_pkg;

  // ****************************************
  // Register command codes
  // ****************************************
  localparam logic [7:0] ADDR_SLOT_A_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_SLOT_B_STATUS     = 8'h05;
  localparam logic [7:0] ADDR_COMMON_STATUS     = 8'h06;
  localparam logic [7:0] ADDR_SPECIAL_FUNCTION  = 8'h07;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SS_FAULT_BIT  = 7;
  localparam int SS_MAIN_BIT   = 6;
  localparam int SS_AUX_BIT    = 5;
  localparam int SS_AUXOC_BIT  = 4;
  localparam int SS_R12OC_BIT  = 2;
  localparam int SS_R3OC_BIT   = 0;
  localparam int CS_MASK_BIT   = 3;
  localparam int CS_UV_BIT     = 2;
  localparam int CS_OT_BIT     = 1;
  localparam int FN_AUXB_BIT   = 7;
  localparam int FN_AUXA_BIT   = 6;
  localparam int FN_POFFB_BIT  = 5;
  localparam int FN_POFFA_BIT  = 4;
  localparam int FN_MAINB_BIT  = 3;
  localparam int FN_MAINA_BIT  = 2;
  localparam int FN_SIG_BIT    = 0;

  // ****************************************
  // Reset values and write masks
  // ****************************************
  localparam logic [7:0] RST_SLOT_STATUS   = 8'h00;
  localparam logic [7:0] RST_COMMON_STATUS = 8'h00;
  localparam logic [7:0] RST_FUNCTION      = 8'h0d;
  localparam logic [7:0] SS_WRITE_MASK     = 8'h15;
  localparam logic [7:0] CS_WRITE_MASK     = 8'h0e;
  localparam logic [7:0] FN_WRITE_MASK     = 8'hcc;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ          = 25_000_000;
  localparam int DEGLITCH_MS     = 5;
  localparam int DEGLITCH_CYCLES = (CLK_HZ / 1000) * DEGLITCH_MS;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic main_en;
    logic aux_en;
    logic main_fault;
    logic uvlo;
    logic force_active;
    logic aux_oc;
    logic r12_oc;
    logic r3_oc;
    logic timer_expired;
    logic r12_fast_trip;
    logic r3_fast_trip;
    logic below_100mv;
  } spsr_slot_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spsr_req_t;

endpackage : spsr_pkg

// ===== spsr_asserts.sv
// Checker of the register bank's port behaviour.
`timescale 1ns/1ps
module spsr_asserts (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic                clk_en,
  // Access port
  input wire spsr_pkg::spsr_req_t req,
  input wire logic [7:0]          rdata,
  input wire logic                rvalid,
  // Pins and limits
  input wire logic                smbus_mode,
  input wire logic [1:0]          force_on_pin_n,
  input wire logic [1:0]          aux_high_pin,
  input wire logic [1:0]          fault_pin_oe_n,
  input wire logic                irq_pin_oe_n,
  input wire logic [1:0]          aux_limit_high
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [7:0] last_a;
  logic       fn_rd;
  logic       ss_rd;
  always_ff @(posedge clk_sys) begin
    if (clk_en) last_a <= req.addr;
  end
  assign fn_rd = rvalid && last_a == spsr_pkg::ADDR_SPECIAL_FUNCTION;
  assign ss_rd = rvalid && last_a[7:1] == 7'h02;
  a_sig_bit_set: assert property (fn_rd |-> rdata[0])
    else $error("signature bit low");
  a_func_nonzero: assert property (fn_rd |-> rdata != 8'h00 && !rdata[1])
    else $error("function read invalid");
  a_slot_rsvd_zero: assert property (ss_rd |-> !rdata[3] && !rdata[1])
    else $error("slot status reserved bit set");
  a_common_rsvd_zero: assert property (rvalid && last_a == 8'h06 |-> !rdata[0])
    else $error("common status reserved bit set");
  a_unmapped_reads_zero: assert property (rvalid && last_a[7:2] != 6'h01 |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_read_gets_answer: assert property (req.rd && clk_en |=> rvalid)
    else $error("read not answered");
  a_bus_mode_open: assert property (smbus_mode [*4] |-> fault_pin_oe_n == 2'b11)
    else $error("fault pin driven in bus mode");
  a_force_opens_pin: assert property ((!force_on_pin_n[0]) [*4] |-> fault_pin_oe_n[0])
    else $error("fault pin driven while forced");
  a_aux_pin_high: assert property (aux_high_pin[0] [*4] |-> aux_limit_high[0])
    else $error("aux pin did not force high limit");
  cover property (ss_rd && rdata[4]);
  cover property (!irq_pin_oe_n);
  cover property (!fault_pin_oe_n[0]);
endmodule : spsr_asserts

bind spsr_regs spsr_asserts u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .req(req), .rdata(rdata), .rvalid(rvalid),
  .smbus_mode(smbus_mode), .force_on_pin_n(force_on_pin_n), .aux_high_pin(aux_high_pin),
  .fault_pin_oe_n(fault_pin_oe_n), .irq_pin_oe_n(irq_pin_oe_n),
  .aux_limit_high(aux_limit_high));

// ===== spsr_host.sv
// Host model that drives register reads and writes on the access port.
`timescale 1ns/1ps
module spsr_host (
  // Clock
  input  wire logic           clk_sys,
  // Access port
  output spsr_pkg::spsr_req_t req,
  input  wire logic [7:0]     rdata,
  input  wire logic           rvalid
);
  initial req = '0;
  // A released request shows inverted fields, so a stale value can never match.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req <= '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_sys);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    req <= '{1'b0, 1'b0, ~a, 8'hff};
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rvalid === 1'b1) begin
        d = rdata;
        ok = 1'b1;
      end else begin
        @(negedge clk_sys);
      end
    end
  endtask : rd_reg
endmodule : spsr_host

// ===== slot_power_status_registers_bench.sv
// Self-checking testbench of the slot power status register bank.
`timescale 1ns/1ps
module slot_power_status_registers_bench;
  logic                 clk_sys, rst_n, clk_en, smbus_mode, ts1, ts2, ok, rvalid, irq_o, irq_oe_n;
  logic [7:0]           rdata, d;
  logic [3:0]           gpi;
  logic [1:0]           fon_n, ahi, fpo, fpoe_n, alh, mnle;
  spsr_pkg::spsr_req_t  req;
  spsr_pkg::spsr_slot_t slot_a, slot_b;
  int                   n_fail, checked;
  logic [11:0]          cond [3];
  logic [7:0]           flag [3];

  spsr_regs #(.DEGLITCH(4)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .req(req), .rdata(rdata),
    .rvalid(rvalid), .slot_a(slot_a), .slot_b(slot_b), .smbus_mode(smbus_mode),
    .thermal_stage_one(ts1), .thermal_stage_two(ts2), .force_on_pin_n(fon_n),
    .aux_high_pin(ahi), .general_input(gpi), .fault_pin_o(fpo),
    .fault_pin_oe_n(fpoe_n), .irq_pin_o(irq_o), .irq_pin_oe_n(irq_oe_n),
    .aux_limit_high(alh), .main_normal_limit_en(mnle));
  spsr_host host (.clk_sys(clk_sys), .req(req), .rdata(rdata), .rvalid(rvalid));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.rd_reg(a, d, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: read not answered", $time);
      end_sim();
    end
    cmp(d, exp);
  endtask : rd
  // Pins pass two sync stages and an output stage, so six cycles leave margin.
  task automatic settle();
    repeat (6) @(negedge clk_sys);
  endtask : settle
  task automatic end_sim();
    $display("checked %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    n_fail = 0;
    checked = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    {smbus_mode, ts1, ts2, fon_n, ahi, gpi} = 11'b000_11_00_0000;
    slot_a = '0;
    slot_b = '0;
    cond = '{12'h048, 12'h004, 12'h010};
    flag = '{8'h10, 8'h04, 8'h01};
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    cmp({4'h0, alh, mnle}, 8'h03);
    for (int i = 0; i < 4; i++) begin
      rd(8'h04 + 8'(i), (i == 3) ? 8'h0d : 8'h00);
    end
    rd(8'h01, 8'h00);
    // A write made while the clock enable is low must leave no trace.
    clk_en = 1'b0;
    host.wr_reg(8'h07, 8'h01);
    clk_en = 1'b1;
    rd(8'h07, 8'h0d);
    host.wr_reg(8'h07, 8'hcd);
    settle();
    rd(8'h07, 8'hcd);
    cmp({4'h0, alh, mnle}, 8'h0f);
    host.wr_reg(8'h07, 8'h02);
    rd(8'h07, 8'hcd);
    host.wr_reg(8'h07, 8'h01);
    ahi = 2'b01;
    settle();
    rd(8'h07, 8'h01);
    cmp({4'h0, alh, mnle}, 8'h04);
    ahi = 2'b00;
    host.wr_reg(8'h07, 8'h0d);
    slot_a.below_100mv = 1'b1;
    settle();
    rd(8'h07, 8'h1d);
    slot_a = 12'hc00;
    settle();
    rd(8'h04, 8'h60);
    slot_a.force_active = 1'b1;
    settle();
    rd(8'h04, 8'h20);
    slot_a = '0;
    smbus_mode = 1'b1;
    for (int k = 0; k < 3; k++) begin
      slot_b = cond[k];
      ts1 = (k == 2);
      settle();
      slot_b = '0;
      ts1 = 1'b0;
      settle();
      cmp({7'h0, irq_oe_n}, 8'h00);
      rd(8'h05, flag[k]);
      host.wr_reg(8'h05, flag[k]);
      rd(8'h05, flag[k]);
      rd(8'h05, 8'h00);
      settle();
      cmp({7'h0, irq_oe_n}, 8'h01);
    end
    host.wr_reg(8'h06, 8'h08);
    slot_b = 12'h004;
    settle();
    cmp({7'h0, irq_oe_n}, 8'h01);
    host.wr_reg(8'h05, 8'h04);
    rd(8'h05, 8'h04);
    rd(8'h05, 8'h04);
    slot_b = '0;
    host.wr_reg(8'h05, 8'h04);
    rd(8'h05, 8'h04);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h08);
    host.wr_reg(8'h06, 8'h00);
    slot_a = 12'h900;
    ts2 = 1'b1;
    settle();
    slot_a = 12'h800;
    ts2 = 1'b0;
    settle();
    rd(8'h06, 8'h06);
    host.wr_reg(8'h06, 8'h06);
    rd(8'h06, 8'h06);
    rd(8'h06, 8'h00);
    slot_a.uvlo = 1'b1;
    settle();
    slot_a = 12'h100;
    settle();
    rd(8'h06, 8'h00);
    slot_a = 12'h200;
    smbus_mode = 1'b0;
    settle();
    cmp({6'h0, fpoe_n}, 8'h02);
    cmp({5'h0, fpo, irq_o}, 8'h00);
    rd(8'h04, 8'h80);
    fon_n = 2'b10;
    settle();
    cmp({6'h0, fpoe_n}, 8'h03);
    rd(8'h04, 8'h80);
    fon_n = 2'b11;
    smbus_mode = 1'b1;
    settle();
    rd(8'h04, 8'h00);
    slot_a = '0;
    gpi = 4'b1010;
    settle();
    settle();
    rd(8'h06, 8'ha0);
    end_sim();
  end
endmodule : slot_power_status_registers_bench
